// ==== rtl/lpsc_ctl.sv ====
module lpsc_ctl
  import lpsc_pkg::*;
#(
  parameter int MISS_SLOTS = LPSC_MISS_SLOTS
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire lpsc_op_type req_op,
  input wire logic [LPSC_ADDR_W-1:0] req_addr,
  input wire logic req_l1_miss,
  input wire logic req_l2_hit,
  input wire logic store_valid,
  input wire logic [LPSC_ADDR_W-1:0] store_addr,
  input wire logic store_streaming,
  input wire logic store_wc_region,
  input wire logic store_fence,
  input wire logic wc_drained,
  input wire logic fill_valid,
  input wire logic [LPSC_SLOT_W-1:0] fill_slot,
  input wire logic evict_valid,
  input wire logic evict_nt,
  input wire logic evict_was_in_l2,
  output logic req_ready,
  output logic store_ready,
  output logic mem_rd_valid,
  output logic [LPSC_ADDR_W-1:0] mem_rd_addr,
  output logic [LPSC_SLOT_W-1:0] mem_rd_slot,
  output logic mem_rd_nt,
  output logic mem_rd_l2_hit,
  output logic [1:0] mem_rd_fill_state,
  output logic [LPSC_WAY_SPAN_BITS-LPSC_LINE_BITS-1:0] mem_rd_set,
  output logic wc_valid,
  output logic [LPSC_ADDR_W-1:0] wc_addr,
  output logic l2_install,
  output logic [LPSC_SLOT_W:0] miss_count
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    lpsc_state_type fsm;
    logic [LPSC_MISS_SLOTS-1:0] busy;
    logic [LPSC_SLOT_W:0] count;
    logic req_ready;
    logic store_ready;
    logic rd_valid;
    logic [LPSC_ADDR_W-1:0] rd_addr;
    logic [LPSC_SLOT_W-1:0] rd_slot;
    logic rd_nt;
    logic rd_l2_hit;
    logic [1:0] rd_fill_state;
    logic [LPSC_WAY_SPAN_BITS-LPSC_LINE_BITS-1:0] rd_set;
    logic wc_valid;
    logic [LPSC_ADDR_W-1:0] wc_addr;
    logic l2_install;
  } lpsc_ctl_type;

  lpsc_ctl_type state;
  lpsc_ctl_type next_state;
  logic hw_pf_valid;
  logic [LPSC_ADDR_W-1:0] hw_pf_addr;
  logic hw_pf_nt;
  logic hw_pf_taken;

  function automatic logic [LPSC_SLOT_W-1:0] lpsc_first_free(input logic [LPSC_MISS_SLOTS-1:0] busy);
    logic [LPSC_SLOT_W-1:0] idx;
    idx = '0;
    for (int i = LPSC_MISS_SLOTS - 1; i >= 0; i--) begin
      if (!busy[i]) begin
        idx = LPSC_SLOT_W'(i);
      end
    end
    return idx;
  endfunction

  lpsc_stream_trainer u_trainer (
    .clk(clk),
    .reset_n(reset_n),
    .miss_valid(req_valid && state.req_ready && req_l1_miss),
    .miss_addr(req_addr),
    .miss_nontemporal(req_op == LPSC_OP_NT_PF),
    .pf_taken(hw_pf_taken),
    .pf_valid(hw_pf_valid),
    .pf_addr(hw_pf_addr),
    .pf_nontemporal(hw_pf_nt)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [LPSC_MISS_SLOTS-1:0] busy_now;
    logic [LPSC_SLOT_W:0] count_now;
    logic slot_free;
    logic [LPSC_SLOT_W-1:0] slot;
    logic take_req;
    busy_now = state.busy;
    count_now = state.count;
    slot_free = 1'b0;
    slot = '0;
    take_req = 1'b0;
    next_state = state;
    next_state.rd_valid = 1'b0;
    next_state.wc_valid = 1'b0;
    next_state.l2_install = 1'b0;
    hw_pf_taken = 1'b0;

    // ----------------------------------------------------------------
    // Slot accounting and request issue
    // ----------------------------------------------------------------
    // A slot frees only on its own fill; a stalled request may use it on the next cycle.
    if (fill_valid && state.busy[fill_slot]) begin
      busy_now[fill_slot] = 1'b0;
      count_now = count_now - 1'b1;
    end
    slot_free = count_now < (LPSC_SLOT_W + 1)'(MISS_SLOTS);
    slot = lpsc_first_free(busy_now);
    // Requests are taken one a cycle in arrival order, so prefetches stay in issue order.
    take_req = req_valid && state.req_ready;
    if (take_req && req_l1_miss) begin
      busy_now[slot] = 1'b1;
      count_now = count_now + 1'b1;
      next_state.rd_valid = 1'b1;
      next_state.rd_addr = lpsc_line_addr(req_addr);
      next_state.rd_slot = slot;
      next_state.rd_nt = req_op == LPSC_OP_NT_PF;
      next_state.rd_l2_hit = req_l2_hit;
      next_state.rd_set = lpsc_set_index(req_addr);
      case (req_op)
        LPSC_OP_WRITE_PF: next_state.rd_fill_state = LPSC_FILL_MODIFIED;
        LPSC_OP_LOAD_PF, LPSC_OP_LVL0_PF, LPSC_OP_LVL1_PF, LPSC_OP_LVL2_PF:
          next_state.rd_fill_state = LPSC_FILL_SHARED;
        default: next_state.rd_fill_state = LPSC_FILL_SHARED;
      endcase
    end else if (!take_req && hw_pf_valid && slot_free) begin
      // Hardware stream prefetches use only cycles left idle by the core.
      hw_pf_taken = 1'b1;
      busy_now[slot] = 1'b1;
      count_now = count_now + 1'b1;
      next_state.rd_valid = 1'b1;
      next_state.rd_addr = hw_pf_addr;
      next_state.rd_slot = slot;
      next_state.rd_nt = hw_pf_nt;
      next_state.rd_l2_hit = 1'b0;
      next_state.rd_set = lpsc_set_index(hw_pf_addr);
      next_state.rd_fill_state = LPSC_FILL_SHARED;
    end
    next_state.busy = busy_now;
    next_state.count = count_now;
    // Ready is registered, so it looks ahead one request.
    next_state.req_ready = count_now < (LPSC_SLOT_W + 1)'(MISS_SLOTS - 1) ||
                           (count_now == (LPSC_SLOT_W + 1)'(MISS_SLOTS - 1) && !(take_req && req_l1_miss));

    // ----------------------------------------------------------------
    // Store path and fence
    // ----------------------------------------------------------------
    // Streaming and combinable stores never take a miss slot and never read memory.
    if (store_valid && state.store_ready) begin
      if (store_streaming || store_wc_region) begin
        next_state.wc_valid = 1'b1;
        next_state.wc_addr = store_addr;
      end
    end
    case (state.fsm)
      LPSC_ST_IDLE: begin
        next_state.store_ready = 1'b1;
        if (store_fence) begin
          next_state.fsm = LPSC_ST_FENCE;
          next_state.store_ready = 1'b0;
        end else if (!next_state.req_ready) begin
          next_state.fsm = LPSC_ST_STALL;
        end
      end
      LPSC_ST_STALL: begin
        // A fence seen while requests stall must still hold back later stores.
        if (store_fence) begin
          next_state.fsm = LPSC_ST_FENCE;
          next_state.store_ready = 1'b0;
        end else if (next_state.req_ready) begin
          next_state.fsm = LPSC_ST_IDLE;
        end
      end
      LPSC_ST_FENCE: begin
        // Later stores wait until every earlier combined write has left the buffers.
        if (wc_drained && !state.wc_valid) begin
          next_state.fsm = LPSC_ST_IDLE;
          next_state.store_ready = 1'b1;
        end
      end
      default: next_state.fsm = LPSC_ST_IDLE;
    endcase

    // ----------------------------------------------------------------
    // Evictions
    // ----------------------------------------------------------------
    if (evict_valid) begin
      next_state.l2_install = !evict_nt || evict_was_in_l2;
    end
  end

  // ----------------------------------------------------------------
  // Registers and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= '{fsm: LPSC_ST_IDLE, req_ready: 1'b1, store_ready: 1'b1, default: '0};
    end else begin
      state <= next_state;
    end
  end

  assign req_ready = state.req_ready;
  assign store_ready = state.store_ready;
  assign mem_rd_valid = state.rd_valid;
  assign mem_rd_addr = state.rd_addr;
  assign mem_rd_slot = state.rd_slot;
  assign mem_rd_nt = state.rd_nt;
  assign mem_rd_l2_hit = state.rd_l2_hit;
  assign mem_rd_fill_state = state.rd_fill_state;
  assign mem_rd_set = state.rd_set;
  assign wc_valid = state.wc_valid;
  assign wc_addr = state.wc_addr;
  assign l2_install = state.l2_install;
  assign miss_count = state.count;
endmodule

// ==== rtl/lpsc_pkg.sv ====
package lpsc_pkg;
  // ----------------------------------------------------------------
  // Geometry and limits
  // ----------------------------------------------------------------
  localparam int LPSC_ADDR_W = 48;
  localparam int LPSC_LINE_BITS = 6;
  localparam int LPSC_WAY_SPAN_BITS = 15;
  localparam int LPSC_MISS_SLOTS = 8;
  localparam int LPSC_SLOT_W = 3;
  localparam int LPSC_STREAM_INIT = 3;
  localparam logic [2:0] LPSC_STREAM_INIT_W3 = 3'h3;

  // ----------------------------------------------------------------
  // Request and fill encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LPSC_OP_LOAD_PF = 3'h0,
    LPSC_OP_LVL0_PF = 3'h1,
    LPSC_OP_LVL1_PF = 3'h2,
    LPSC_OP_LVL2_PF = 3'h3,
    LPSC_OP_WRITE_PF = 3'h4,
    LPSC_OP_NT_PF = 3'h5,
    LPSC_OP_DEMAND = 3'h6
  } lpsc_op_type;

  typedef enum logic [1:0] {
    LPSC_FILL_SHARED = 2'h0,
    LPSC_FILL_MODIFIED = 2'h1
  } lpsc_fill_state_type;

  typedef enum logic [2:0] {
    LPSC_ST_IDLE = 3'b001,
    LPSC_ST_STALL = 3'b010,
    LPSC_ST_FENCE = 3'b100
  } lpsc_state_type;

  function automatic logic [LPSC_ADDR_W-1:0] lpsc_line_addr(input logic [LPSC_ADDR_W-1:0] a);
    return {a[LPSC_ADDR_W-1:LPSC_LINE_BITS], {LPSC_LINE_BITS{1'b0}}};
  endfunction

  function automatic logic [LPSC_WAY_SPAN_BITS-LPSC_LINE_BITS-1:0] lpsc_set_index(
      input logic [LPSC_ADDR_W-1:0] a);
    return a[LPSC_WAY_SPAN_BITS-1:LPSC_LINE_BITS];
  endfunction
endpackage

// ==== rtl/lpsc_stream_trainer.sv ====
module lpsc_stream_trainer
  import lpsc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic miss_valid,
  input wire logic [LPSC_ADDR_W-1:0] miss_addr,
  input wire logic miss_nontemporal,
  input wire logic pf_taken,
  output logic pf_valid,
  output logic [LPSC_ADDR_W-1:0] pf_addr,
  output logic pf_nontemporal
);
  // ----------------------------------------------------------------
  // Single stream tracker
  // ----------------------------------------------------------------
  typedef struct packed {
    logic last_valid;
    logic [LPSC_ADDR_W-LPSC_LINE_BITS-1:0] last_line;
    logic [2:0] remaining;
    logic [LPSC_ADDR_W-LPSC_LINE_BITS-1:0] next_line;
    logic nontemporal;
  } lpsc_trainer_type;

  lpsc_trainer_type state;
  lpsc_trainer_type next_state;
  logic [LPSC_ADDR_W-LPSC_LINE_BITS-1:0] miss_line;

  assign miss_line = miss_addr[LPSC_ADDR_W-1:LPSC_LINE_BITS];

  always_comb begin
    next_state = state;
    if (pf_taken && state.remaining != 3'h0) begin
      next_state.remaining = state.remaining - 3'h1;
      next_state.next_line = state.next_line + 1'b1;
    end
    if (miss_valid) begin
      next_state.last_valid = 1'b1;
      next_state.last_line = miss_line;
      if (state.last_valid && miss_line == state.last_line + 1'b1) begin
        next_state.remaining = LPSC_STREAM_INIT_W3;
        next_state.next_line = miss_line + 1'b1;
        next_state.nontemporal = miss_nontemporal;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pf_valid = state.remaining != 3'h0;
  assign pf_addr = {state.next_line, {LPSC_LINE_BITS{1'b0}}};
  assign pf_nontemporal = state.nontemporal;
endmodule

// ==== tb/lpsc_ctl_properties.sv ====
module lpsc_ctl_properties
  import lpsc_pkg::*;
#(
  parameter int MISS_SLOTS = LPSC_MISS_SLOTS
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire lpsc_op_type req_op,
  input wire logic req_l1_miss,
  input wire logic req_l2_hit,
  input wire logic store_valid,
  input wire logic store_streaming,
  input wire logic store_wc_region,
  input wire logic store_fence,
  input wire logic wc_drained,
  input wire logic fill_valid,
  input wire logic evict_valid,
  input wire logic evict_nt,
  input wire logic evict_was_in_l2,
  input wire logic req_ready,
  input wire logic store_ready,
  input wire logic mem_rd_valid,
  input wire logic [LPSC_ADDR_W-1:0] mem_rd_addr,
  input wire logic mem_rd_nt,
  input wire logic mem_rd_l2_hit,
  input wire logic [1:0] mem_rd_fill_state,
  input wire logic [LPSC_WAY_SPAN_BITS-LPSC_LINE_BITS-1:0] mem_rd_set,
  input wire logic wc_valid,
  input wire logic l2_install,
  input wire logic [LPSC_SLOT_W:0] miss_count
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence miss_taken;
    req_valid && req_ready && req_l1_miss;
  endsequence
  chk_slot_cap: assert property (miss_count <= 4'(MISS_SLOTS))
    else $error("too many outstanding misses");
  chk_full_stall: assert property (miss_count == 4'(MISS_SLOTS) |-> !req_ready)
    else $error("request accepted with all slots busy");
  chk_count_up: assert property (miss_taken ##0 !fill_valid |=> miss_count == $past(miss_count) + 4'h1)
    else $error("miss count did not grow");
  chk_fill_frees: assert property (fill_valid && miss_count == 4'(MISS_SLOTS) |=> req_ready)
    else $error("slot not released by fill");
  chk_line_whole: assert property (mem_rd_valid |-> mem_rd_addr[5:0] == 6'h0 && mem_rd_set == mem_rd_addr[14:6])
    else $error("read not line aligned or wrong set");
  chk_hint_fill: assert property (miss_taken ##0 req_op inside {[LPSC_OP_LOAD_PF:LPSC_OP_LVL2_PF]}
    |=> mem_rd_valid && mem_rd_fill_state == 2'h0 && !mem_rd_nt) else $error("hinted prefetch differs");
  chk_write_mod: assert property (miss_taken ##0 req_op == LPSC_OP_WRITE_PF |=> mem_rd_fill_state == 2'h1)
    else $error("write prefetch not modified");
  chk_nt_tag: assert property (miss_taken ##0 req_op == LPSC_OP_NT_PF
    |=> mem_rd_nt && mem_rd_l2_hit == $past(req_l2_hit)) else $error("nontemporal read untagged");
  chk_store_wc: assert property (store_valid && store_ready && (store_streaming || store_wc_region) |=> wc_valid)
    else $error("store not combined");
  chk_fence_block: assert property (store_fence && store_ready |=> !store_ready)
    else $error("fence ignored");
  chk_fence_drain: assert property ($rose(store_ready) |-> $past(wc_drained))
    else $error("fence released before drain");
  chk_evict_l2: assert property (1'b1 |=> l2_install == $past(evict_valid && (!evict_nt || evict_was_in_l2)))
    else $error("wrong install on eviction");
endmodule

bind lpsc_ctl lpsc_ctl_properties #(.MISS_SLOTS(MISS_SLOTS)) i_lpsc_ctl_properties (.*);

// ==== tb/lpsc_mem_model.sv ====
module lpsc_mem_model
  import lpsc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hold,
  input wire logic mem_rd_valid,
  input wire logic [LPSC_SLOT_W-1:0] mem_rd_slot,
  input wire logic wc_valid,
  output logic fill_valid,
  output logic [LPSC_SLOT_W-1:0] fill_slot,
  output logic wc_drained
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [LPSC_SLOT_W-1:0] q[$];
  int wc_busy = 0;
  initial fill_valid = 1'b0;
  initial fill_slot = '0;
  // Fills return oldest first, every other cycle; the idle slot value toggles so it never looks valid.
  always @(posedge clk) begin
    fill_valid <= 1'b0;
    fill_slot <= ~fill_slot;
    if (!reset_n) begin
      q.delete();
      wc_busy <= 0;
    end else begin
      if (mem_rd_valid) q.push_back(mem_rd_slot);
      if (!hold && q.size() > 0 && !fill_valid) begin
        fill_valid <= 1'b1;
        fill_slot <= q.pop_front();
      end
      wc_busy <= wc_valid ? 6 : (wc_busy > 0 ? wc_busy - 1 : 0);
    end
  end
  assign wc_drained = (wc_busy == 0);
endmodule

// ==== tb/l1_prefetch_stream_store_ctl_test.sv ====
module l1_prefetch_stream_store_ctl_test
  import lpsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_l1_miss = 1'b0, req_l2_hit = 1'b0, hold = 1'b1;
  logic store_valid = 1'b0, store_streaming = 1'b0, store_wc_region = 1'b0, store_fence = 1'b0;
  logic evict_valid = 1'b0, evict_nt = 1'b0, evict_was_in_l2 = 1'b0;
  lpsc_op_type req_op = LPSC_OP_LOAD_PF;
  logic [LPSC_ADDR_W-1:0] req_addr = '0, store_addr = '0, mem_rd_addr, wc_addr;
  logic wc_drained, fill_valid, req_ready, store_ready, mem_rd_valid, mem_rd_nt, mem_rd_l2_hit, wc_valid, l2_install;
  logic [LPSC_SLOT_W-1:0] fill_slot, mem_rd_slot;
  logic [1:0] mem_rd_fill_state;
  logic [LPSC_WAY_SPAN_BITS-LPSC_LINE_BITS-1:0] mem_rd_set;
  logic [LPSC_SLOT_W:0] miss_count;
  logic [50:0] rd_q[$];
  logic [3:0] slot_q[$];
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  lpsc_ctl i_lpsc_ctl (.*);
  lpsc_mem_model i_lpsc_mem_model (.*);
  initial forever #12.5 clk = ~clk;
  // Under two hundred cycles are needed, so the ceiling of 20000 cycles leaves wide margin.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (mem_rd_valid) rd_q.push_back({mem_rd_nt, mem_rd_fill_state, mem_rd_addr});
    if (mem_rd_valid) slot_q.push_back({mem_rd_l2_hit, mem_rd_slot});
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic step();
    @(posedge clk);
    #2;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [50:0] exp_rd(input lpsc_op_type op, input logic [47:0] a);
    return {op == LPSC_OP_NT_PF, op == LPSC_OP_WRITE_PF ? 2'h1 : 2'h0, a[47:6], 6'h0};
  endfunction
  // Leaves req_valid high so back-to-back requests never toggle it within one step.
  task automatic req(input lpsc_op_type op, input logic [47:0] a);
    req_valid = 1'b1;
    req_op = op;
    req_addr = a;
    req_l1_miss = 1'b1;
    req_l2_hit = 1'($urandom);
    for (int n = 0; n < 200 && !req_ready; n++) step();
    step();
  endtask
  initial begin
    logic [47:0] a;
    logic [50:0] got;
    lpsc_op_type op;
    void'($urandom(46));
    repeat (4) step();
    reset_n = 1'b1;
    // ----------------------------------------------------------------
    // Every request kind with fills held back, then the ninth stalls
    // ----------------------------------------------------------------
    for (int i = 0; i < 9; i++) begin
      if (i == 8) hold = 1'b0;
      op = lpsc_op_type'(i % 7);
      a = 48'({$urandom, $urandom});
      req(op, a);
      req_valid = 1'b0;
      step();
      check(64'(rd_q.pop_front()), 64'(exp_rd(op, a)));
      check(64'(slot_q.pop_front()), 64'({req_l2_hit, 3'(i % 8)}));
      if (i == 7) check(64'({req_ready, miss_count}), 64'({1'b0, 4'h8}));
    end
    repeat (30) step();
    rd_q.delete();
    slot_q.delete();
    // ----------------------------------------------------------------
    // Stream training by two line misses, plain and nontemporal
    // ----------------------------------------------------------------
    for (int j = 0; j < 2; j++) begin
      op = j ? LPSC_OP_NT_PF : LPSC_OP_LOAD_PF;
      a = 48'({$urandom, 12'h0});
      req(op, a);
      req(op, a + 48'h40);
      req_valid = 1'b0;
      repeat (25) step();
      check(64'(rd_q.size()), 64'd5);
      for (int k = 0; k < 5; k++) begin
        got = rd_q.pop_front();
        check(64'({got[50], got[47:0]}), 64'({j == 1, a + 48'(64 * k)}));
      end
    end
    // An L1 hit takes no slot and sends no read.
    req_l1_miss = 1'b0;
    req_valid = 1'b1;
    step();
    req_valid = 1'b0;
    step();
    check(64'({rd_q.size() == 0, miss_count}), 64'({1'b1, 4'h0}));
    // ----------------------------------------------------------------
    // Stores, fence and evictions
    // ----------------------------------------------------------------
    for (int i = 0; i < 12; i++) begin
      {store_streaming, store_wc_region} = 2'(i < 4 ? i : $urandom);
      store_addr = 48'({$urandom, $urandom});
      store_valid = 1'b1;
      step();
      store_valid = 1'b0;
      check(64'({wc_valid, rd_q.size() == 0}), 64'({store_streaming | store_wc_region, 1'b1}));
      if (store_streaming | store_wc_region) check(64'(wc_addr), 64'(store_addr));
      step();
    end
    store_streaming = 1'b1;
    store_valid = 1'b1;
    step();
    store_valid = 1'b0;
    store_fence = 1'b1;
    step();
    store_fence = 1'b0;
    check(64'(store_ready), 64'd0);
    for (int n = 0; n < 50 && !store_ready; n++) step();
    check(64'({store_ready, wc_drained}), 64'h3);
    for (int i = 0; i < 4; i++) begin
      {evict_nt, evict_was_in_l2} = 2'(i);
      evict_valid = 1'b1;
      step();
      evict_valid = 1'b0;
      check(64'(l2_install), 64'(i != 2));
      step();
    end
    summarize();
  end
endmodule
